// ==== src/sai_alu.v ====
// Shader ALU slice: int-to-float, attribute loads, interpolation, discard, group sync
`include "sai_map.vh"

// What this block does
// - Opcode 155 converts first source operand, a signed integer, to float.
// - Opcode 224 loads vertex A attribute data from shared memory into registers.
// - First source operand holds attribute index; issuer keeps it in 0 to 32.
// - Opcode 225 loads vertex B minus vertex A attribute data.
// - Opcode 226 loads vertex C minus vertex A attribute data.
// - Attributes are held per primitive at three vertices A, B and C.
// - Opcode 216 uses lanes x,y: y multiply-adds, x adds via dot path.
// - Final dot-path add takes multiply-add result unrounded and unnormalised.
// - Opcode 214 uses all lanes; lane y's interpolated y goes to y output.
// - Opcode 217 uses lanes w,z: w multiply-adds, z adds via dot path.
// - Opcode 215 uses all lanes; z result to y output, w result to w.
// - Discard-if-equal writes 1.0 and sets discard when equal, else 0.0.
// - Discard honoured only in a pixel program, ignored in all others.
// - Issuer places discard last in its clause; later ops miss the update.
// - Opcode 84 in the operation select field is work-group synchronisation.
// - Each operation is an operand select word plus a two-source op word.
// - Synchronisation holds each arrived thread until all active group threads have arrived.
// - Opcode 44 in the operation select field is float discard-if-equal.
module sai_alu #(
    parameter THREADS = 4,
    parameter TID_W = 2
) (
    // Clock and reset
    input wire clk_in,
    input wire resetn_in,
    // Instruction issue
    input wire issue_valid_in,
    input wire [31:0] operand_select_word_in,
    input wire [31:0] two_source_op_word_in,
    input wire [TID_W-1:0] thread_id_in,
    input wire pixel_program_in,
    // Fetched operands, lanes packed w,z,y,x from high to low
    input wire [127:0] first_source_operand_in,
    input wire [127:0] second_source_in,
    input wire [127:0] vertex_a_in,
    input wire [127:0] edge_ab_in,
    input wire [127:0] edge_ac_in,
    input wire [31:0] bary_i_in,
    input wire [31:0] bary_j_in,
    // Shared memory attribute fill
    input wire shm_wr_en_in,
    input wire [1:0] shm_wr_vertex_in,
    input wire [5:0] shm_wr_param_in,
    input wire [127:0] shm_wr_data_in,
    // Thread bookkeeping
    input wire [THREADS-1:0] thread_active_in,
    input wire [THREADS-1:0] invocation_start_in,
    // Results
    output reg result_valid_out,
    output reg [127:0] result_data_out,
    output reg [3:0] result_mask_out,
    output reg param_range_err_out,
    output reg unknown_op_out,
    output reg [THREADS-1:0] discard_out,
    output reg [THREADS-1:0] sync_hold_out
);

// ----------------------------------------------------------------------
// Decode
// ----------------------------------------------------------------------
localparam K_NONE = 4'h0;
localparam K_CONVERT = 4'h1;
localparam K_LOAD_A = 4'h2;
localparam K_LOAD_AB = 4'h3;
localparam K_LOAD_AC = 4'h4;
localparam K_BLEND_X = 4'h5;
localparam K_BLEND_XY = 4'h6;
localparam K_BLEND_Z = 4'h7;
localparam K_BLEND_ZW = 4'h8;
localparam K_DISCARD = 4'h9;
localparam K_SYNC = 4'ha;

function [3:0] op_kind;
    input [10:0] op;
    begin
        case (op)
            `SAI_OP_SIGNED_TO_REAL: op_kind = K_CONVERT;
            `SAI_OP_VERTEX_A_LOAD: op_kind = K_LOAD_A;
            `SAI_OP_EDGE_AB_LOAD: op_kind = K_LOAD_AB;
            `SAI_OP_EDGE_AC_LOAD: op_kind = K_LOAD_AC;
            `SAI_OP_LANE_X_BLEND: op_kind = K_BLEND_X;
            `SAI_OP_LANES_XY_BLEND: op_kind = K_BLEND_XY;
            `SAI_OP_LANE_Z_BLEND: op_kind = K_BLEND_Z;
            `SAI_OP_LANES_ZW_BLEND: op_kind = K_BLEND_ZW;
            `SAI_OP_DISCARD_EQ: op_kind = K_DISCARD;
            `SAI_OP_GROUP_SYNC: op_kind = K_SYNC;
            default: op_kind = K_NONE;
        endcase
    end
endfunction

// Operand select word carries source selects only; operands arrive fetched
wire [10:0] op_field = two_source_op_word_in[`SAI_OP_MSB:`SAI_OP_LSB];
wire [3:0] kind = op_kind(op_field);
wire [31:0] unused_sel = operand_select_word_in;

// ----------------------------------------------------------------------
// Arithmetic helpers
// ----------------------------------------------------------------------
// Round to nearest even, exactly as a cast would
function [31:0] int_to_real;
    input [31:0] v;
    reg s;
    reg [31:0] a;
    reg [31:0] n;
    reg [24:0] m;
    reg [4:0] p;
    reg up;
    integer k;
    begin
        s = v[31];
        a = s ? (~v + 32'h00000001) : v;
        p = 5'h00;
        for (k = 0; k < 32; k = k + 1) begin
            if (a[k]) p = k[4:0];
        end
        n = a << (5'h1f - p);
        up = n[7] & ((|n[6:0]) | n[8]);
        m = {2'b01, n[30:8]} + {24'h000000, up};
        if (a == 32'h00000000) begin
            int_to_real = `SAI_FLOAT_ZERO;
        end else if (m[24]) begin
            int_to_real = {s, 8'h7f + {3'h0, p} + 8'h01, 23'h000000};
        end else begin
            int_to_real = {s, 8'h7f + {3'h0, p}, m[22:0]};
        end
    end
endfunction

// Float equality: NaN never equal, signed zeros equal
function real_equal;
    input [31:0] a;
    input [31:0] b;
    reg nan_a;
    reg nan_b;
    begin
        nan_a = (a[30:23] == 8'hff) && (a[22:0] != 23'h000000);
        nan_b = (b[30:23] == 8'hff) && (b[22:0] != 23'h000000);
        if (nan_a || nan_b) begin
            real_equal = 1'b0;
        end else if ((a[30:0] == 31'h00000000) && (b[30:0] == 31'h00000000)) begin
            real_equal = 1'b1;
        end else begin
            real_equal = (a == b);
        end
    end
endfunction

// Multiply-add stage: wide sum kept at full precision
function [63:0] fused_mul_add_stage;
    input [31:0] ab;
    input [31:0] ac;
    input [31:0] i;
    input [31:0] j;
    begin
        fused_mul_add_stage = $signed(ab) * $signed(i) + $signed(ac) * $signed(j);
    end
endfunction

// Dot-path add: no rounding or normalise of the multiply-add result
function [31:0] inner_product_adder;
    input [31:0] base;
    input [63:0] mad;
    reg [63:0] sum;
    begin
        sum = {{(32-`SAI_FIX_FRAC){base[31]}}, base, {`SAI_FIX_FRAC{1'b0}}} + mad;
        inner_product_adder = sum[`SAI_FIX_FRAC+31:`SAI_FIX_FRAC];
    end
endfunction

// ----------------------------------------------------------------------
// Shared memory attribute store, three vertices per parameter
// ----------------------------------------------------------------------
localparam DEPTH = `SAI_VERTEX_COUNT * `SAI_PARAM_COUNT;
reg [127:0] local_shared_memory [0:DEPTH-1];

wire [5:0] param_idx = first_source_operand_in[5:0];
wire param_ok = (first_source_operand_in[31:6] == 26'h0000000) &&
    (param_idx <= `SAI_PARAM_MAX);
wire [5:0] safe_idx = param_ok ? param_idx : 6'h00;
wire [6:0] rd_base = {1'b0, safe_idx} * 7'h03;
wire [6:0] wr_addr = {1'b0, shm_wr_param_in} * 7'h03 + {5'h00, shm_wr_vertex_in};
wire wr_ok = shm_wr_en_in && (shm_wr_param_in <= `SAI_PARAM_MAX) && (shm_wr_vertex_in != 2'h3);
wire [127:0] attr_a = local_shared_memory[rd_base];
wire [127:0] attr_b = local_shared_memory[rd_base + 7'h01];
wire [127:0] attr_c = local_shared_memory[rd_base + 7'h02];

always @(posedge clk_in) begin
    if (wr_ok) begin
        local_shared_memory[wr_addr] <= shm_wr_data_in;
    end
end

// ----------------------------------------------------------------------
// Per-lane datapath
// ----------------------------------------------------------------------
wire [127:0] conv_v;
wire [127:0] delta_ab_v;
wire [127:0] delta_ac_v;
wire [127:0] blend_v;

genvar g;
generate
    for (g = 0; g < 4; g = g + 1) begin : lane
        wire [63:0] mad;
        assign conv_v[32*g+31:32*g] = int_to_real(first_source_operand_in[32*g+31:32*g]);
        assign delta_ab_v[32*g+31:32*g] = attr_b[32*g+31:32*g] - attr_a[32*g+31:32*g];
        assign delta_ac_v[32*g+31:32*g] = attr_c[32*g+31:32*g] - attr_a[32*g+31:32*g];
        assign mad = fused_mul_add_stage(edge_ab_in[32*g+31:32*g], edge_ac_in[32*g+31:32*g],
            bary_i_in, bary_j_in);
        assign blend_v[32*g+31:32*g] = inner_product_adder(vertex_a_in[32*g+31:32*g], mad);
    end
endgenerate

wire discard_hit = real_equal(first_source_operand_in[31:0], second_source_in[31:0]);

// ----------------------------------------------------------------------
// Result selection
// ----------------------------------------------------------------------
reg [127:0] next_data;
reg [3:0] next_mask;
reg next_range_err;
reg next_unknown;

always @* begin
    next_data = 128'h0;
    next_mask = 4'h0;
    next_range_err = 1'b0;
    next_unknown = 1'b0;
    case (kind)
        K_CONVERT: begin
            next_data = conv_v;
            next_mask = 4'hf;
        end
        K_LOAD_A, K_LOAD_AB, K_LOAD_AC: begin
            next_range_err = ~param_ok;
            next_mask = param_ok ? 4'hf : 4'h0;
            if (kind == K_LOAD_A) begin
                next_data = attr_a;
            end else if (kind == K_LOAD_AB) begin
                next_data = delta_ab_v;
            end else begin
                next_data = delta_ac_v;
            end
        end
        K_BLEND_X: begin
            next_data = {96'h0, blend_v[31:0]};
            next_mask = 4'h1;
        end
        K_BLEND_XY: begin
            next_data = {64'h0, blend_v[63:32], blend_v[31:0]};
            next_mask = 4'h3;
        end
        K_BLEND_Z: begin
            next_data = {32'h0, blend_v[95:64], 64'h0};
            next_mask = 4'h4;
        end
        K_BLEND_ZW: begin
            next_data = {blend_v[127:96], 32'h0, blend_v[95:64], 32'h0};
            next_mask = 4'ha;
        end
        K_DISCARD: begin
            if (pixel_program_in) begin
                next_data = {96'h0, discard_hit ? `SAI_FLOAT_ONE : `SAI_FLOAT_ZERO};
                next_mask = 4'h1;
            end
        end
        K_SYNC: begin
            next_mask = 4'h0;
        end
        default: begin
            next_unknown = 1'b1;
        end
    endcase
end

// ----------------------------------------------------------------------
// Discard flags and group synchronisation
// ----------------------------------------------------------------------
wire [THREADS-1:0] tid_onehot = {{(THREADS-1){1'b0}}, 1'b1} << thread_id_in;
wire discard_fire = issue_valid_in && (kind == K_DISCARD) && pixel_program_in && discard_hit;
wire sync_fire = issue_valid_in && (kind == K_SYNC);
wire [THREADS-1:0] arrived = sync_hold_out | (sync_fire ? tid_onehot : {THREADS{1'b0}});
// Release only once every active thread has arrived
wire all_in = ((arrived & thread_active_in) == thread_active_in) && (|arrived);

always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        discard_out <= {THREADS{1'b0}};
        sync_hold_out <= {THREADS{1'b0}};
    end else begin
        // Set beats a same-cycle invocation restart
        discard_out <= (discard_out & ~invocation_start_in) |
            (discard_fire ? tid_onehot : {THREADS{1'b0}});
        sync_hold_out <= all_in ? {THREADS{1'b0}} : arrived;
    end
end

// ----------------------------------------------------------------------
// Output registers
// ----------------------------------------------------------------------
always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        result_valid_out <= 1'b0;
        result_data_out <= 128'h0;
        result_mask_out <= 4'h0;
        param_range_err_out <= 1'b0;
        unknown_op_out <= 1'b0;
    end else begin
        result_valid_out <= issue_valid_in && (kind != K_SYNC) && (kind != K_NONE);
        result_data_out <= issue_valid_in ? next_data : result_data_out;
        result_mask_out <= issue_valid_in ? next_mask : 4'h0;
        param_range_err_out <= issue_valid_in && next_range_err;
        unknown_op_out <= issue_valid_in && next_unknown;
    end
end

endmodule // sai_alu

// ==== src/sai_map.vh ====
// Opcode, field and constant map for the shader interpolation/discard ALU slice
`ifndef SAI_MAP_VH
`define SAI_MAP_VH

// ----------------------------------------------------------------------
// Operation select field inside the two-source operation word
// ----------------------------------------------------------------------
`define SAI_OP_LSB 7
`define SAI_OP_MSB 17

// ----------------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------------
`define SAI_OP_SIGNED_TO_REAL 11'h09b
`define SAI_OP_VERTEX_A_LOAD 11'h0e0
`define SAI_OP_EDGE_AB_LOAD 11'h0e1
`define SAI_OP_EDGE_AC_LOAD 11'h0e2
`define SAI_OP_LANE_X_BLEND 11'h0d8
`define SAI_OP_LANES_XY_BLEND 11'h0d6
`define SAI_OP_LANE_Z_BLEND 11'h0d9
`define SAI_OP_LANES_ZW_BLEND 11'h0d7
`define SAI_OP_DISCARD_EQ 11'h02c
`define SAI_OP_GROUP_SYNC 11'h054

// ----------------------------------------------------------------------
// Attribute store layout and float constants
// ----------------------------------------------------------------------
`define SAI_PARAM_MAX 6'h20
`define SAI_PARAM_COUNT 33
`define SAI_VERTEX_COUNT 3
`define SAI_FLOAT_ONE 32'h3f800000
`define SAI_FLOAT_ZERO 32'h00000000
`define SAI_FIX_FRAC 16

`endif

// ==== tb/sai_alu_monitor.sv ====
// Port-level assertions for the shader ALU slice
`include "sai_map.vh"
module sai_alu_monitor #(
    parameter THREADS = 4,
    parameter TID_W = 2
) (
    input wire clk_in, resetn_in, issue_valid_in, pixel_program_in,
    input wire [31:0] two_source_op_word_in,
    input wire [TID_W-1:0] thread_id_in,
    input wire [127:0] first_source_operand_in, second_source_in, result_data_out,
    input wire [THREADS-1:0] invocation_start_in, discard_out, sync_hold_out,
    input wire result_valid_out, param_range_err_out, unknown_op_out,
    input wire [3:0] result_mask_out
);
    timeunit 1ns;
    timeprecision 1ps;
    wire [10:0] op = two_source_op_word_in[`SAI_OP_MSB:`SAI_OP_LSB];
    wire [31:0] ax = first_source_operand_in[31:0];
    wire [31:0] bx = second_source_in[31:0];
    wire ld = op == `SAI_OP_VERTEX_A_LOAD || op == `SAI_OP_EDGE_AB_LOAD ||
        op == `SAI_OP_EDGE_AC_LOAD;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_take(logic [10:0] code);
        issue_valid_in && op == code;
    endsequence
    sequence s_answer(logic [3:0] m);
        result_valid_out && result_mask_out == m && !unknown_op_out;
    endsequence
    a_convert_lanes: assert property (
        s_take(`SAI_OP_SIGNED_TO_REAL) |=> s_answer(4'hf)) else $error("convert answer");
    a_load_in_range: assert property (
        issue_valid_in && ld && ax <= 32 |=> s_answer(4'hf) ##0 !param_range_err_out)
        else $error("load answer");
    a_load_range_err: assert property (
        issue_valid_in && ld && ax > 32 |=> param_range_err_out && result_mask_out == 4'h0)
        else $error("load range flag");
    a_blend_x: assert property (
        s_take(`SAI_OP_LANE_X_BLEND) |=> s_answer(4'h1)) else $error("x blend mask");
    a_blend_xy: assert property (
        s_take(`SAI_OP_LANES_XY_BLEND) |=> s_answer(4'h3)) else $error("xy blend mask");
    a_blend_z: assert property (
        s_take(`SAI_OP_LANE_Z_BLEND) |=> s_answer(4'h4)) else $error("z blend mask");
    a_blend_zw: assert property (
        s_take(`SAI_OP_LANES_ZW_BLEND) |=> s_answer(4'ha)) else $error("zw blend mask");
    a_discard_equal: assert property (
        s_take(`SAI_OP_DISCARD_EQ) ##0 pixel_program_in && ax == bx && ax[30:23] != 8'hff
        |=> discard_out[$past(thread_id_in)] && result_data_out[31:0] == `SAI_FLOAT_ONE)
        else $error("discard on equal");
    a_discard_ignored: assert property (
        s_take(`SAI_OP_DISCARD_EQ) ##0 !pixel_program_in |=> result_valid_out &&
        result_mask_out == 4'h0 && (discard_out & ~$past(discard_out)) == 0)
        else $error("discard outside pixel program");
    a_discard_sticky: assert property (
        ($past(discard_out) & ~$past(invocation_start_in) & ~discard_out) == 0)
        else $error("discard flag dropped");
    a_sync_quiet: assert property (
        s_take(`SAI_OP_GROUP_SYNC) |=> !result_valid_out && !unknown_op_out)
        else $error("sync gave a result");
    a_sync_held: assert property (
        sync_hold_out != 0 && !issue_valid_in |=> sync_hold_out == $past(sync_hold_out))
        else $error("barrier hold changed");
endmodule // sai_alu_monitor

bind sai_alu sai_alu_monitor #(.THREADS(THREADS), .TID_W(TID_W)) i_mon (.clk_in(clk_in),
    .resetn_in(resetn_in), .issue_valid_in(issue_valid_in), .pixel_program_in(pixel_program_in),
    .two_source_op_word_in(two_source_op_word_in), .thread_id_in(thread_id_in),
    .first_source_operand_in(first_source_operand_in), .second_source_in(second_source_in),
    .result_data_out(result_data_out), .invocation_start_in(invocation_start_in),
    .discard_out(discard_out), .sync_hold_out(sync_hold_out),
    .result_valid_out(result_valid_out), .param_range_err_out(param_range_err_out),
    .unknown_op_out(unknown_op_out), .result_mask_out(result_mask_out));

// ==== tb/sai_seq_model.sv ====
// Shader sequencer model issuing one instruction pair at a time
module sai_seq_model #(
    parameter TID_W = 2
) (
    input wire clk_in,
    output logic issue_valid_out,
    output logic [31:0] word0_out,
    output logic [31:0] word1_out,
    output logic [TID_W-1:0] tid_out,
    output logic pixel_out,
    output logic [127:0] first_source_operand_out,
    output logic [127:0] src1_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {issue_valid_out, word0_out, word1_out, tid_out, pixel_out, first_source_operand_out, src1_out} = '0;
    end
    // One instruction per clause: a discard always closes it, no sync in flow control
    task automatic send(input logic [10:0] op, input logic [127:0] a, b,
        input logic [TID_W-1:0] t, input logic p);
        @(negedge clk_in);
        issue_valid_out = 1'b1;
        word0_out = a[31:0] ^ b[63:32];
        word1_out = {14'h0, op, 7'h0};
        tid_out = t;
        pixel_out = p;
        first_source_operand_out = a;
        src1_out = b;
        @(negedge clk_in);
        issue_valid_out = 1'b0;
        // Released lines must not keep looking valid
        word1_out = ~word1_out;
        first_source_operand_out = ~first_source_operand_out;
        src1_out = ~src1_out;
    endtask
endmodule // sai_seq_model

// ==== tb/shader_alu_interp_kill_ops_bench.sv ====
// Self-checking bench for the shader ALU slice
`include "sai_map.vh"
module shader_alu_interp_kill_ops_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic wr_en = 1'b0;
    logic iv, pix, vld, err, unk;
    logic [1:0] tid;
    logic [1:0] wr_v = 2'h0;
    logic [5:0] wr_p = 6'h0;
    logic [3:0] inv = 4'h0, ed = 4'h0, act = 4'hf, mask, disc, hold;
    logic [31:0] w0, w1, bi = 32'h0, bj = 32'h0;
    logic [127:0] s0, s1, dat, e, va = '0, eb = '0, ec = '0, wr_d = '0;
    logic [127:0] mem [0:2][0:32];
    logic [10:0] ops [0:3] = '{`SAI_OP_LANE_X_BLEND, `SAI_OP_LANES_XY_BLEND,
        `SAI_OP_LANE_Z_BLEND, `SAI_OP_LANES_ZW_BLEND};
    logic [3:0] msk [0:3] = '{4'h1, 4'h3, 4'h4, 4'ha};
    logic [31:0] da [0:5] = '{32'h3f800000, 32'h0, 32'h7fc00000, 32'h40000000, 32'h3f800000,
        32'h1};
    logic [31:0] db [0:5] = '{32'h3f800000, 32'h80000000, 32'h7fc00000, 32'h3f800000,
        32'h3f800000, 32'h2};
    logic [5:0] dpix = 6'h2f;
    logic [5:0] deq = 6'h13;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    int seed = 32'h65d3fc2a;
    int k;
    int p;

    sai_seq_model #(.TID_W(2)) i_seq (.clk_in(clk_in), .issue_valid_out(iv), .word0_out(w0),
        .word1_out(w1), .tid_out(tid), .pixel_out(pix), .first_source_operand_out(s0), .src1_out(s1));
    sai_alu i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .issue_valid_in(iv),
        .operand_select_word_in(w0), .two_source_op_word_in(w1), .thread_id_in(tid),
        .pixel_program_in(pix), .first_source_operand_in(s0), .second_source_in(s1),
        .vertex_a_in(va), .edge_ab_in(eb), .edge_ac_in(ec), .bary_i_in(bi), .bary_j_in(bj),
        .shm_wr_en_in(wr_en), .shm_wr_vertex_in(wr_v), .shm_wr_param_in(wr_p),
        .shm_wr_data_in(wr_d), .thread_active_in(act), .invocation_start_in(inv),
        .result_valid_out(vld), .result_data_out(dat), .result_mask_out(mask),
        .param_range_err_out(err), .unknown_op_out(unk), .discard_out(disc),
        .sync_hold_out(hold));

    always #2 clk_in = ~clk_in;

    function automatic [127:0] r128();
        r128 = {$random(seed), $random(seed), $random(seed), $random(seed)};
    endfunction
    // Round to nearest even on the bits shifted out
    function automatic [31:0] i2f(input [31:0] v);
        logic [31:0] m;
        logic [63:0] t;
        int x;
        m = v[31] ? -v : v;
        x = 31;
        if (m == 32'h0) return 32'h0;
        while (!m[x]) x--;
        t = {32'h0, m} << (63 - x);
        return {v[31], 8'(x + 127), t[62:40]} + 32'(t[39] & (t[40] | (|t[38:0])));
    endfunction
    function automatic [31:0] ip(input int q);
        return 32'(((longint'($signed(va[q*32+:32])) <<< 16)
            + longint'($signed(eb[q*32+:32])) * $signed(bi)
            + longint'($signed(ec[q*32+:32])) * $signed(bj)) >>> 16);
    endfunction
    function automatic [127:0] sub(input [127:0] a, b);
        for (int q = 0; q < 4; q++) sub[q*32+:32] = a[q*32+:32] - b[q*32+:32];
    endfunction

    task automatic chk(input logic [127:0] g, x);
        checks++;
        if (g !== x) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic run(input [10:0] op, input [127:0] a, b, input [3:0] m, input [127:0] x);
        logic [127:0] l;
        l = {{32{m[3]}}, {32{m[2]}}, {32{m[1]}}, {32{m[0]}}};
        i_seq.send(op, a, b, 2'h0, 1'b1);
        chk(vld, 1'b1);
        chk(mask, m);
        chk(dat & l, x & l);
    endtask
    task print_verdict;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            print_verdict();
        end
    end

    initial begin
        repeat (5) @(negedge clk_in);
        resetn_in = 1'b1;
        // Last write targets the absent fourth vertex and must be dropped
        for (k = 0; k < 100; k++) begin
            @(negedge clk_in);
            wr_en = 1'b1;
            wr_v = k < 99 ? 2'(k / 33) : 2'h3;
            wr_p = 6'(k % 33);
            wr_d = r128();
            if (k < 99) mem[k / 33][k % 33] = wr_d;
        end
        @(negedge clk_in);
        wr_en = 1'b0;
        for (k = 0; k < 12; k++) begin
            p = k < 3 ? 0 : k < 6 ? 32 : {$random(seed)} % 33;
            e = k % 3 ? sub(mem[k % 3][p], mem[0][p]) : mem[0][p];
            run(`SAI_OP_VERTEX_A_LOAD + 11'(k % 3), 128'(p), r128(), 4'hf, e);
        end
        for (k = 0; k < 2; k++) begin
            i_seq.send(`SAI_OP_EDGE_AC_LOAD, k ? 128'h21 : 128'hffffffff, '0, 2'h0, 1'b1);
            chk(err, 1'b1);
        end
        for (k = 0; k < 10; k++) begin
            e = k == 0 ? {32'h80000000, 32'h7fffffff, 32'h01000001, 32'hffffffff} :
                k == 1 ? {32'h0, 32'h5, 32'h7fffffc0, 32'h02000003} : r128();
            s0 = {i2f(e[127:96]), i2f(e[95:64]), i2f(e[63:32]), i2f(e[31:0])};
            run(`SAI_OP_SIGNED_TO_REAL, e, r128(), 4'hf, s0);
        end
        for (k = 0; k < 12; k++) begin
            va = r128();
            eb = r128();
            ec = r128();
            bi = {16'h0, 16'($random(seed))};
            bj = {16'h0, 16'($random(seed))};
            e = {ip(3), ip(2), ip(1), ip(0)};
            if (k % 4 == 3) e = {e[127:96], 32'h0, e[95:64], 32'h0};
            run(ops[k % 4], r128(), r128(), msk[k % 4], e);
        end
        for (k = 0; k < 6; k++) begin
            ed[k % 4] = ed[k % 4] | (deq[k] & dpix[k]);
            i_seq.send(`SAI_OP_DISCARD_EQ, 128'(da[k]), 128'(db[k]), 2'(k % 4), dpix[k]);
            chk(dat[31:0], deq[k] & dpix[k] ? `SAI_FLOAT_ONE : `SAI_FLOAT_ZERO);
            chk(mask, 4'(dpix[k]));
            chk(disc, ed);
        end
        @(negedge clk_in);
        inv = 4'h1;
        @(negedge clk_in);
        inv = 4'h0;
        chk(disc, 4'h2);
        for (k = 0; k < 4; k++) begin
            i_seq.send(`SAI_OP_GROUP_SYNC, r128(), r128(), 2'(k), 1'b0);
            chk(hold, k < 3 ? 4'((1 << (k + 1)) - 1) : 4'h0);
            chk(vld, 1'b0);
        end
        // Inactive threads must not be waited for
        act = 4'h5;
        for (k = 0; k < 2; k++) begin
            i_seq.send(`SAI_OP_GROUP_SYNC, r128(), r128(), 2'(2 * k), 1'b0);
            chk(hold, k ? 4'h0 : 4'h1);
        end
        i_seq.send(11'h7ff, r128(), r128(), 2'h0, 1'b1);
        chk(unk, 1'b1);
        print_verdict();
    end
endmodule // shader_alu_interp_kill_ops_bench
